// file: gpio_pkg.sv
// Purpose: shared constants for the four parallel ports
// Assumes: register index times four is the wishbone byte address
// Notes:   data registers are eight bits wide except port b's three, upper bus bits read zero
package gpio_pkg;

	// register indices, byte address is index * 4
	localparam logic [5:0] IDX_PORT_A     = 6'h01;
	localparam logic [5:0] IDX_PORT_B     = 6'h02;
	localparam logic [5:0] IDX_PORT_C     = 6'h03;
	localparam logic [5:0] IDX_PORT_D     = 6'h04;
	localparam logic [5:0] IDX_PORT_B_PIN = 6'h0a;
	localparam logic [5:0] IDX_PORT_A_DIR = 6'h0d;
	localparam logic [5:0] IDX_PORT_C_DIR = 6'h0e;
	localparam logic [5:0] IDX_PORT_D_DIR = 6'h0f;
	localparam logic [5:0] IDX_CONV_CTL   = 6'h1c;
	localparam logic [5:0] IDX_CLK_MODE   = 6'h30;

	// field positions
	localparam int unsigned ADIS_BIT      = 4;
	localparam int unsigned CHAN_LSB      = 0;
	localparam int unsigned CHAN_W        = 3;
	localparam int unsigned DUAL_CLK_BIT  = 0;

	// reset values
	localparam logic [7:0] RST_A_LATCH    = 8'h00;
	localparam logic [7:0] RST_A_DIR      = 8'h00;
	localparam logic [2:0] RST_B_LATCH    = 3'h7;
	localparam logic [7:0] RST_C_LATCH    = 8'h00;
	localparam logic [7:0] RST_C_DIR      = 8'h00;
	localparam logic [7:0] RST_D_LATCH    = 8'h00;
	localparam logic [7:0] RST_D_DIR      = 8'h00;
	localparam logic       RST_ADIS       = 1'b1;
	localparam logic [2:0] RST_CHAN       = 3'h0;
	localparam logic       RST_DUAL_CLK   = 1'b0;

	// one-hot mask for the selected analog channel
	function automatic logic [7:0] chan_mask(input logic [2:0] ch);
		chan_mask = 8'h01 << ch;
	endfunction

endpackage

// file: gpio_ports.sv
`timescale 1ns/100ps
// Purpose: four parallel ports behind a classic wishbone slave
// Assumes: 100 MHz clk_sys, synchronous active-high reset
// Notes:   ack one cycle after request; pins sampled on that edge
//
// What this block does
// [R01] port a bit is input when its direction bit is 0, output when 1
// [R02] reset clears port a direction and latches, all pins input
// [R03] latch writes land whatever the direction setting
// [R04] software sets latch to 1 before making a port a pin output
// [R05] software keeps direction 0 for port a inputs
// [R06] port b has three bits, latches set to 1 on reset
// [R07] software keeps port b latch at 1 for inputs and alternates
// [R08] dual-clock mode gives port b bits 1 and 2 to the crystal
// [R09] falling edge on port b bit 0 sets its interrupt request
// [R10] port b latch and pin levels read at separate addresses
// [R11] port b read bits 7 to 3 carry no defined value
// [R12] reset clears port c direction and sets analog disable
// [R13] selected analog pin is analog while analog disable is 0
// [R14] converter on: selected pin reads 0, others read normally
// [R15] software keeps digital port c inputs off the analog channel
// [R16] software keeps port c outputs off the analog channel
// [R17] software avoids port c writes during conversion
// [R18] read returns pin for input bits and latch for output bits
// [R19] read-modify-write writes pin levels into input-bit latches
// [R20] port d: direction 0 input, 1 output; reset clears both
// [R21] pins sampled at read, outputs change on the write edge; the pin enables change one cycle after it
// [R22] an output pin drives its latch until latch or direction change
module gpio_ports
	import gpio_pkg::*;
(
	input  wire logic        clk_sys,        // system clock
	input  wire logic        rst,            // sync reset, active high
	input  wire logic        wb_cyc_i,       // bus cycle
	input  wire logic        wb_stb_i,       // strobe
	input  wire logic        wb_we_i,        // write enable
	input  wire logic [7:0]  wb_adr_i,       // byte address
	input  wire logic [3:0]  wb_sel_i,       // byte selects
	input  wire logic [31:0] wb_dat_i,       // write data
	output logic      [31:0] wb_dat_o,       // read data
	output logic             wb_ack_o,       // acknowledge
	input  wire logic [7:0]  port_a_in,      // port a pin levels
	output logic      [7:0]  port_a_out,     // port a drive value
	output logic      [7:0]  port_a_oe_n,    // port a enable, low drives
	input  wire logic [2:0]  port_b_in,      // port b pin levels
	output logic      [2:0]  port_b_out,     // port b drive value
	output logic      [2:0]  port_b_oe_n,    // port b enable, low drives
	input  wire logic [7:0]  port_c_in,      // port c pin levels
	output logic      [7:0]  port_c_out,     // port c drive value
	output logic      [7:0]  port_c_oe_n,    // port c enable, low drives
	input  wire logic [7:0]  port_d_in,      // port d pin levels
	output logic      [7:0]  port_d_out,     // port d drive value
	output logic      [7:0]  port_d_oe_n,    // port d enable, low drives
	output logic             ext_int0_req,   // port b bit 0 fall pulse
	output logic             crystal_en,     // crystal owns b bits 1,2
	output logic             analog_enable,  // converter input active
	output logic      [2:0]  analog_chan     // selected analog pin
);
	port_if #(.W(8)) pa ();
	port_if #(.W(8)) pc ();
	port_if #(.W(8)) pd ();

	logic [26:0] pins_sync;
	logic [2:0]  b_pins;
	logic [2:0]  b_latch_ff;
	logic        aind_ff;
	logic        conv_on_ff;
	logic [2:0]  chsel_ff;
	logic        dual_ff;
	logic        b0_prev_ff;
	logic        int0_ff;
	logic        ack_ff;
	logic [31:0] dat_ff;
	logic [7:0]  a_oe_n_ff;
	logic [2:0]  b_oe_n_ff;
	logic [7:0]  c_oe_n_ff;
	logic [7:0]  d_oe_n_ff;
	logic [5:0]  idx;
	logic        req;
	logic        wr_go;
	logic [7:0]  wdat;
	logic [7:0]  amask;
	logic [7:0]  c_read;
	logic [2:0]  xtal_mask;
	logic [7:0]  rd_byte;

	// all pins through one synchroniser
	input_sync #(.W(27)) u_sync
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       ({port_d_in, port_c_in, port_b_in, port_a_in}),
		.q       (pins_sync)
	);

	assign pa.pins = pins_sync[7:0];
	assign b_pins  = pins_sync[10:8];
	assign pc.pins = pins_sync[18:11];
	assign pd.pins = pins_sync[26:19];

	// direction-controlled ports
	port_bank #(.W(8), .RST_LATCH(RST_A_LATCH), .RST_DIR(RST_A_DIR)) u_a
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.pb      (pa)
	);
	port_bank #(.W(8), .RST_LATCH(RST_C_LATCH), .RST_DIR(RST_C_DIR)) u_c
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.pb      (pc)
	);
	port_bank #(.W(8), .RST_LATCH(RST_D_LATCH), .RST_DIR(RST_D_DIR)) u_d
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.pb      (pd)
	);

	// bus decode
	assign idx   = wb_adr_i[7:2];
	assign req   = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_go = req & wb_we_i & wb_sel_i[0];
	assign wdat  = wb_dat_i[7:0];

	// write strobes, whole byte replaces the latch
	assign pa.wr_dat   = wdat;
	assign pc.wr_dat   = wdat;
	assign pd.wr_dat   = wdat;
	assign pa.wr_latch = wr_go & (idx == IDX_PORT_A); // see [R19]
	assign pa.wr_dir   = wr_go & (idx == IDX_PORT_A_DIR);
	assign pc.wr_latch = wr_go & (idx == IDX_PORT_C); // see [R19]
	assign pc.wr_dir   = wr_go & (idx == IDX_PORT_C_DIR);
	assign pd.wr_latch = wr_go & (idx == IDX_PORT_D); // see [R20]
	assign pd.wr_dir   = wr_go & (idx == IDX_PORT_D_DIR);

	// analog channel and crystal masks
	assign amask     = aind_ff ? 8'h00 : chan_mask(chsel_ff); // see [R13]
	assign xtal_mask = dual_ff ? 3'h6 : 3'h0;                // see [R08]
	assign c_read    = pc.rd_val & ~amask;                   // see [R14]

	// read selection, unmapped reads zero
	always_comb
	begin
		case (idx)
			IDX_PORT_A:     rd_byte = pa.rd_val;           // see [R18]
			IDX_PORT_B:     rd_byte = {5'h00, b_latch_ff}; // see [R10]
			IDX_PORT_C:     rd_byte = c_read;
			IDX_PORT_D:     rd_byte = pd.rd_val;
			IDX_PORT_B_PIN: rd_byte = {5'h00, b_pins};     // see [R11]
			IDX_PORT_A_DIR: rd_byte = pa.dir;
			IDX_PORT_C_DIR: rd_byte = pc.dir;
			IDX_PORT_D_DIR: rd_byte = pd.dir;
			IDX_CONV_CTL:   rd_byte = {3'h0, aind_ff, 1'b0, chsel_ff};
			IDX_CLK_MODE:   rd_byte = {7'h00, dual_ff};
			default:        rd_byte = 8'h00;
		endcase
	end

	// bus answer, pins sampled on the answering edge
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end
		else
		begin
			ack_ff <= req;
			if (req && !wb_we_i)
				dat_ff <= {24'h00_0000, rd_byte}; // see [R21]
		end
	end

	// port b latch, converter and clock-mode controls
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			b_latch_ff <= RST_B_LATCH; // see [R06]
			aind_ff    <= RST_ADIS;    // see [R12]
			conv_on_ff <= ~RST_ADIS;
			chsel_ff   <= RST_CHAN;
			dual_ff    <= RST_DUAL_CLK;
		end
		else
		begin
			if (wr_go && idx == IDX_PORT_B)
				b_latch_ff <= wdat[2:0]; // see [R03]
			if (wr_go && idx == IDX_CONV_CTL)
			begin
				aind_ff    <= wdat[ADIS_BIT];
				conv_on_ff <= ~wdat[ADIS_BIT];
				chsel_ff   <= wdat[CHAN_LSB +: CHAN_W];
			end
			if (wr_go && idx == IDX_CLK_MODE)
				dual_ff <= wdat[DUAL_CLK_BIT];
		end
	end

	// pin enables, low drives the latch value
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			a_oe_n_ff <= 8'hff; // see [R02]
			b_oe_n_ff <= 3'h7;
			c_oe_n_ff <= 8'hff; // see [R12]
			d_oe_n_ff <= 8'hff; // see [R20]
		end
		else
		begin
			a_oe_n_ff <= ~pa.dir;                    // see [R01]
			b_oe_n_ff <= b_latch_ff | xtal_mask;     // see [R08]
			c_oe_n_ff <= ~(pc.dir & ~amask);         // see [R13]
			d_oe_n_ff <= ~pd.dir;                    // see [R20]
		end
	end

	// falling edge on port b bit 0, any direction
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			b0_prev_ff <= 1'b0;
			int0_ff    <= 1'b0;
		end
		else
		begin
			b0_prev_ff <= b_pins[0];
			int0_ff    <= b0_prev_ff & ~b_pins[0]; // see [R09]
		end
	end

	// outputs straight from flops
	assign wb_ack_o      = ack_ff;
	assign wb_dat_o      = dat_ff;
	assign port_a_out    = pa.latch; // see [R22]
	assign port_a_oe_n   = a_oe_n_ff;
	assign port_b_out    = b_latch_ff;
	assign port_b_oe_n   = b_oe_n_ff;
	assign port_c_out    = pc.latch;
	assign port_c_oe_n   = c_oe_n_ff;
	assign port_d_out    = pd.latch;
	assign port_d_oe_n   = d_oe_n_ff;
	assign ext_int0_req  = int0_ff;
	assign crystal_en    = dual_ff;
	assign analog_enable = conv_on_ff;
	assign analog_chan   = chsel_ff;

	// a port c read request while the converter is on
	sequence s_rd_c;
		req && !wb_we_i && idx == IDX_PORT_C && !aind_ff;
	endsequence

	property p_dir_a;
		@(posedge clk_sys) disable iff (rst)
		pa.wr_dir |=> ##1 port_a_oe_n == ~$past(wdat, 2);
	endproperty
	a_dir_a: assert property (p_dir_a) // see [R01]
		else $error("port a enable does not follow direction");

	property p_rst_a;
		@(posedge clk_sys)
		$fell(rst) |-> port_a_oe_n == 8'hff && port_a_out == 8'h00;
	endproperty
	a_rst_a: assert property (p_rst_a) // see [R02]
		else $error("port a not input and clear after reset");

	property p_latch_any_dir;
		@(posedge clk_sys) disable iff (rst)
		(pa.wr_latch && pa.dir == 8'h00) |=> port_a_out == $past(wdat);
	endproperty
	a_latch_any_dir: assert property (p_latch_any_dir) // see [R03]
		else $error("latch write lost while port is input");

	property p_rst_b;
		@(posedge clk_sys)
		$fell(rst) |-> port_b_out == 3'h7 && port_b_oe_n == 3'h7;
	endproperty
	a_rst_b: assert property (p_rst_b) // see [R06]
		else $error("port b latch not set after reset");

	property p_xtal;
		@(posedge clk_sys) disable iff (rst)
		dual_ff [*2] |-> port_b_oe_n[2:1] == 2'b11;
	endproperty
	a_xtal: assert property (p_xtal) // see [R08]
		else $error("crystal pins driven in dual-clock mode");

	property p_int0;
		@(posedge clk_sys) disable iff (rst)
		$fell(b_pins[0]) |=> ext_int0_req ##1 !ext_int0_req;
	endproperty
	a_int0: assert property (p_int0) // see [R09]
		else $error("port b bit 0 fall gave no single pulse");

	property p_b_pins;
		@(posedge clk_sys) disable iff (rst)
		(req && !wb_we_i && idx == IDX_PORT_B_PIN)
		|=> wb_ack_o && wb_dat_o == {29'h0, $past(b_pins)};
	endproperty
	a_b_pins: assert property (p_b_pins) // see [R10]
		else $error("port b pin read wrong");

	property p_rst_c;
		@(posedge clk_sys)
		$fell(rst) |-> !analog_enable && port_c_oe_n == 8'hff;
	endproperty
	a_rst_c: assert property (p_rst_c) // see [R12]
		else $error("port c not digital input after reset");

	property p_analog_pin;
		@(posedge clk_sys) disable iff (rst)
		(!aind_ff && $stable(chsel_ff))
		|=> port_c_oe_n[$past(chsel_ff)] == 1'b1;
	endproperty
	a_analog_pin: assert property (p_analog_pin) // see [R13]
		else $error("analog pin driven");

	property p_c_read;
		@(posedge clk_sys) disable iff (rst)
		s_rd_c |=> wb_dat_o[$past(chsel_ff)] == 1'b0;
	endproperty
	a_c_read: assert property (p_c_read) // see [R14]
		else $error("analog pin read non-zero");

	property p_a_read;
		@(posedge clk_sys) disable iff (rst)
		(req && !wb_we_i && idx == IDX_PORT_A) |=> wb_dat_o[7:0] ==
			(($past(pa.dir) & $past(pa.latch)) |
			(~$past(pa.dir) & $past(pa.pins)));
	endproperty
	a_a_read: assert property (p_a_read) // see [R18]
		else $error("port a read mixes wrong");

	property p_rst_d;
		@(posedge clk_sys)
		$fell(rst) |-> port_d_oe_n == 8'hff && port_d_out == 8'h00;
	endproperty
	a_rst_d: assert property (p_rst_d) // see [R20]
		else $error("port d not cleared after reset");

	property p_hold;
		@(posedge clk_sys) disable iff (rst)
		!pa.wr_latch |=> $stable(port_a_out);
	endproperty
	a_hold: assert property (p_hold) // see [R22]
		else $error("port a output changed without a write");
endmodule

// file: input_sync.sv
`timescale 1ns/100ps
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to clk_sys
// Notes:   a change is taken once stages two and three agree
module input_sync #(parameter int W = 8)
(
	input  wire logic         clk_sys, // system clock
	input  wire logic         rst,     // sync reset, active high
	input  wire logic [W-1:0] d,       // raw pin levels
	output logic      [W-1:0] q        // filtered levels
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff;
	logic [W-1:0] agree;

	// bits whose last two stages match
	assign agree = ~(s2_ff ^ s3_ff);

	// shift chain and filtered output
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			q_ff  <= '0;
		end
		else
		begin
			s1_ff <= d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff  <= (agree & s3_ff) | (~agree & q_ff);
		end
	end

	assign q = q_ff;
endmodule

// file: pin_board.sv
// Purpose: board circuitry seen at the pins of one port
// Assumes: every pin carries a pull-up resistor
// Notes:   board and device driving apart gives x
`timescale 1ns/100ps
module pin_board #(parameter int W = 8)
(
	input  wire logic [W-1:0] drv,  // device drive value
	input  wire logic [W-1:0] oe_n, // device enable, low drives
	input  wire logic [W-1:0] ext,  // board drive value
	input  wire logic [W-1:0] en,   // board drives where 1
	output logic      [W-1:0] pin   // resolved pin level
);
	// resolve each wire, released lines float up
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			if (!oe_n[i] && en[i])
				pin[i] = (drv[i] == ext[i]) ? ext[i] : 1'bx;
			else if (!oe_n[i])
				pin[i] = drv[i];
			else
				pin[i] = en[i] ? ext[i] : 1'b1;
		end
	end
endmodule

// file: port_bank.sv
`timescale 1ns/100ps
// Purpose: direction and latch registers of one port, read mux
// Assumes: strobes are single-cycle from the bus decoder
// Notes:   latch loads regardless of direction
module port_bank #(
	parameter int           W         = 8,
	parameter logic [W-1:0] RST_LATCH = '0,
	parameter logic [W-1:0] RST_DIR   = '0
)
(
	input  wire logic clk_sys, // system clock
	input  wire logic rst,     // sync reset, active high
	port_if.bank      pb       // port control group
);
	logic [W-1:0] latch_ff;
	logic [W-1:0] dir_ff;

	// latch and direction storage
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			latch_ff <= RST_LATCH;
			dir_ff   <= RST_DIR;
		end
		else
		begin
			if (pb.wr_latch)
				latch_ff <= pb.wr_dat; // see [R03]
			if (pb.wr_dir)
				dir_ff <= pb.wr_dat;   // see [R01]
		end
	end

	// inputs read pins, outputs read latch
	assign pb.rd_val = (dir_ff & latch_ff) | (~dir_ff & pb.pins); // see [R18]
	assign pb.latch  = latch_ff;
	assign pb.dir    = dir_ff;
endmodule

// file: port_if.sv
`timescale 1ns/100ps
// Purpose: carries one port's write strobes, state and read value
// Assumes: single clock domain
// Notes:   ctrl side is the bus decoder, bank side holds the registers
interface port_if #(parameter int W = 8);
	logic [W-1:0] wr_dat;   // write data
	logic         wr_latch; // latch write strobe
	logic         wr_dir;   // direction write strobe
	logic [W-1:0] pins;     // synchronised pin levels
	logic [W-1:0] dir;      // direction, 1 = output
	logic [W-1:0] latch;    // output latch
	logic [W-1:0] rd_val;   // per-bit read value

	modport ctrl (output wr_dat, wr_latch, wr_dir, pins,
		input dir, latch, rd_val);
	modport bank (input wr_dat, wr_latch, wr_dir, pins,
		output dir, latch, rd_val);
endinterface

// file: tb_top.sv
// Purpose: self-checking bench for the four parallel ports
// Assumes: ack one cycle after a request
// Notes:   pins need four cycles through the synchroniser
`timescale 1ns/100ps
`define CHK(act, exp) \
	begin \
		n_checks++; \
		if ((act) !== (exp)) \
		begin \
			miscompares++; \
			$display("[ERR] %0t got %h want %h", $time, act, exp); \
		end \
	end
module tb_top;
	import gpio_pkg::*;
	logic        clk_sys, rst, cyc, stb, we, ack;
	logic [7:0]  adr, ext, en_a, en_c, en_d;
	logic [7:0]  pa, pc, pd, oa, oc, od, ea, ec, ed;
	logic [2:0]  pb, ob, eb, en_b, achan;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic        int0, xtal, aen;
	int          miscompares, n_checks;

	// design under test
	gpio_ports i_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.port_a_in(pa), .port_a_out(oa), .port_a_oe_n(ea),
		.port_b_in(pb), .port_b_out(ob), .port_b_oe_n(eb),
		.port_c_in(pc), .port_c_out(oc), .port_c_oe_n(ec),
		.port_d_in(pd), .port_d_out(od), .port_d_oe_n(ed),
		.ext_int0_req(int0), .crystal_en(xtal),
		.analog_enable(aen), .analog_chan(achan));

	// board side of each port
	pin_board #(.W(8)) i_brd_a (.drv(oa), .oe_n(ea), .ext(ext),
		.en(en_a), .pin(pa));
	pin_board #(.W(3)) i_brd_b (.drv(ob), .oe_n(eb), .ext(ext[2:0]),
		.en(en_b), .pin(pb));
	pin_board #(.W(8)) i_brd_c (.drv(oc), .oe_n(ec), .ext(ext),
		.en(en_c), .pin(pc));
	pin_board #(.W(8)) i_brd_d (.drv(od), .oe_n(ed), .ext(ext),
		.en(en_d), .pin(pd));

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	task automatic final_report();
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one classic bus cycle, waits for ack under a bound
	task automatic wb_cycle(input logic w, input logic [5:0] idx,
		input logic [7:0] d, input logic [3:0] s, output logic [31:0] r);
		int n;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1)
		begin
			miscompares++;
			$display("[ERR] %0t no ack", $time);
			final_report();
		end
		else
		begin
			r = rdat;
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic [31:0] r;
		wb_cycle(1'b1, idx, d, 4'h1, r);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] e);
		logic [31:0] r;
		wb_cycle(1'b0, idx, 8'h00, 4'h1, r);
		`CHK(r, {24'h0, e})
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// counts interrupt pulses over a fixed window
	task automatic pulses(input int e);
		int c;
		c = 0;
		repeat (12)
		begin
			@(posedge clk_sys);
			#1;
			if (int0 === 1'b1)
				c++;
		end
		`CHK(c, e)
	endtask

	// mixed directions on a port with a direction register
	task automatic port_mix(input logic [5:0] li, input logic [5:0] di,
		input int p);
		logic [31:0] r;
		@(posedge clk_sys);
		en_a <= 8'hf0;
		en_c <= 8'hf0;
		en_d <= 8'hf0;
		wr(li, 8'ha5);
		`CHK(p == 0 ? oa : p == 1 ? oc : od, 8'ha5)
		wr(di, 8'h0f);
		step(6);
		`CHK(p == 0 ? ea : p == 1 ? ec : ed, 8'hf0)
		rd(di, 8'h0f);
		wb_cycle(1'b0, li, 8'h00, 4'h1, r);
		`CHK(r[7:0], 8'h35)
		wr(li, r[7:0] | 8'h80);
		@(posedge clk_sys);
		en_a <= 8'h00;
		en_c <= 8'h00;
		en_d <= 8'h00;
		wr(di, 8'hff);
		step(6);
		rd(li, 8'hb5);
		`CHK(p == 0 ? oa : p == 1 ? oc : od, 8'hb5)
		wr(di, 8'h00);
	endtask

	// main sequence
	initial
	begin
		logic [31:0] r;
		clk_sys = 1'b0;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		ext = 8'h3c;
		en_a = 8'h00;
		en_b = 3'h0;
		en_c = 8'h00;
		en_d = 8'h00;
		miscompares = 0;
		n_checks = 0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		step(6);
		`CHK({ea, oa}, 16'hff00)
		`CHK({ed, od}, 16'hff00)
		`CHK({ec, aen}, 9'h1fe)
		`CHK(ob, 3'h7)
		rd(IDX_PORT_A_DIR, 8'h00);
		rd(IDX_PORT_C_DIR, 8'h00);
		rd(IDX_PORT_D_DIR, 8'h00);
		rd(IDX_PORT_B, 8'h07);
		rd(IDX_CONV_CTL, 8'h10);
		port_mix(IDX_PORT_A, IDX_PORT_A_DIR, 0);
		port_mix(IDX_PORT_C, IDX_PORT_C_DIR, 1);
		port_mix(IDX_PORT_D, IDX_PORT_D_DIR, 2);
		// port b latch against pin levels
		@(posedge clk_sys);
		ext <= 8'h30;
		en_b <= 3'h4;
		wr(IDX_PORT_B, 8'hfd);
		step(6);
		rd(IDX_PORT_B, 8'h05);
		rd(IDX_PORT_B_PIN, 8'h01);
		wr(IDX_CLK_MODE, 8'h01);
		step(2);
		`CHK({xtal, eb[2:1]}, 3'h7)
		wr(IDX_CLK_MODE, 8'h00);
		step(2);
		`CHK({xtal, eb[1]}, 2'b00)
		// falling edge on bit 0, from board then from latch
		@(posedge clk_sys);
		en_b <= 3'h0;
		wr(IDX_PORT_B, 8'h07);
		step(8);
		@(posedge clk_sys);
		en_b <= 3'h1;
		pulses(1);
		@(posedge clk_sys);
		en_b <= 3'h0;
		step(8);
		wr(IDX_PORT_B, 8'h06);
		pulses(1);
		wr(IDX_PORT_B, 8'h07);
		step(8);
		// analog channel over port c outputs
		wr(IDX_PORT_C, 8'hff);
		wr(IDX_PORT_C_DIR, 8'hff);
		wr(IDX_CONV_CTL, 8'h03);
		step(3);
		`CHK({aen, achan, ec}, 12'hb08)
		rd(IDX_PORT_C, 8'hf7);
		rd(IDX_CONV_CTL, 8'h03);
		wr(IDX_CONV_CTL, 8'h10);
		wr(IDX_PORT_C_DIR, 8'h00);
		step(3);
		`CHK({aen, ec}, 9'h0ff)
		// refused accesses
		wr(6'h05, 8'hff);
		rd(6'h05, 8'h00);
		wb_cycle(1'b1, IDX_PORT_A, 8'h5a, 4'h0, r);
		`CHK(oa, 8'hb5)
		// second reset in mid-run
		@(posedge clk_sys);
		rst <= 1'b1;
		step(4);
		@(posedge clk_sys);
		rst <= 1'b0;
		step(6);
		`CHK(oa, 8'h00)
		rd(IDX_PORT_D_DIR, 8'h00);
		rd(IDX_PORT_B, 8'h07);
		final_report();
	end
endmodule
